// >>> inc/reference_ladder_regs.vh
`ifndef REFERENCE_LADDER_REGS_VH
`define REFERENCE_LADDER_REGS_VH
// register byte offsets
`define REG_LEVEL_CONTROL       16'h9600
`define REG_LEVEL_CONTROL_CLR   16'h9604
`define REG_LEVEL_CONTROL_SET   16'h9608
`define REG_LEVEL_CONTROL_INV   16'h960C
// field positions
`define BIT_ENABLE      15
`define BIT_PIN_OE      6
`define BIT_RANGE       5
`define BIT_SOURCE      4
`define CODE_MSB        3
`define CODE_LSB        0
// implemented bits and reset value
`define CTRL_MASK       32'h0000_807F
`define CTRL_RESET      32'h0000_0000
`define READ_ZERO       32'h0000_0000
// ladder tap decode
`define TAP_LOW_BASE    6'h08
`define TAPS_WIDTH      6
// per-field reset values
`define ENABLE_RESET     1'h0
`define PIN_OE_RESET     1'h0
`define RANGE_RESET      1'h0
`define SOURCE_RESET     1'h0
`define CODE_RESET       4'h0
`define POWER_DOWN_RESET 1'h1
`define PIN_DRIVE_RESET  1'h0
`define TAP_RESET        40'h00_0000_0000
`endif

// >>> src/ladder_tap_decode.v
`include "reference_ladder_regs.vh"
`default_nettype none
// one-hot tap select for the resistor ladder
module ladder_tap_decode (
   input  wire        enable,     // module on
   input  wire        range_sel,  // high range when 1
   input  wire [3:0]  code,       // level code
   output reg  [39:0] tap_onehot  // selected tap, 0 when off
);
   reg [5:0] tap_index;
   // high range: code/24 of span; low range: 8/32 + code/32
   always @* begin
      tap_index = 6'h00;
      tap_onehot = `TAP_RESET;
      if (range_sel) begin
         tap_index = {2'h0, code};
      end else begin
         tap_index = `TAP_LOW_BASE + {2'h0, code};
      end
      if (enable) begin
         tap_onehot[tap_index] = 1'h1;
      end
   end
endmodule
`default_nettype wire

// >>> src/reference_ladder_control.v
// Decided for this implementation: strobed register access.
`include "reference_ladder_regs.vh"
`default_nettype none
module reference_ladder_control (
   input  wire        clk_sys,          // system clock
   input  wire        rst,              // async reset, active high
   input  wire [15:0] addr,             // byte address
   input  wire [31:0] wdata,            // write data
   input  wire        wr,               // write strobe
   input  wire        rd,               // read strobe
   output reg  [31:0] rdata,            // read data, cycle after rd
   output wire        ladder_enable,    // ladder powered
   output wire        level_pin_output_enable, // level to pin
   output wire        range_select,     // 1 = high 0..2/3 range
   output wire        ladder_source_select, // 1 = external refs
   output wire [3:0]  level_code,       // ladder code
   output wire        ladder_power_down, // ladder draws no current
   output wire [39:0] tap_select        // one-hot ladder tap
);

   // stored fields of the control register
   reg         enable;            // module on
   reg         pin_request;       // pin enable as written
   reg         range;             // range select
   reg         source;            // source select
   reg  [3:0]  code;              // level code
   // derived ladder drives, flopped beside the fields
   reg         power_down;        // ladder current off
   reg         pin_drive;         // level routed to pin
   reg  [39:0] tap;               // one-hot ladder tap
   // next values
   reg         next_enable;
   reg         next_pin_request;
   reg         next_range;
   reg         next_source;
   reg  [3:0]  next_code;
   reg         next_power_down;
   reg         next_pin_drive;
   wire [39:0] next_tap;
   reg  [31:0] next_rdata;
   // register word views
   reg  [31:0] ctrl;              // current word, unused bits zero
   reg  [31:0] next_ctrl;         // word after this edge
   wire [31:0] wmask;             // write data, implemented bits only
   // address decode
   wire        hit_base;
   wire        hit_clr;
   wire        hit_set;
   wire        hit_inv;
   wire        hit_any;
   wire        write_hit;
   wire        read_hit;

   // address decode for the base word and its aliases
   assign hit_base  = (addr == `REG_LEVEL_CONTROL);
   assign hit_clr   = (addr == `REG_LEVEL_CONTROL_CLR);
   assign hit_set   = (addr == `REG_LEVEL_CONTROL_SET);
   assign hit_inv   = (addr == `REG_LEVEL_CONTROL_INV);
   assign hit_any   = hit_base | hit_clr | hit_set | hit_inv;
   assign write_hit = wr & hit_any;
   assign read_hit  = rd & hit_any;

   // unimplemented bits never reach the register
   assign wmask = wdata & `CTRL_MASK;

   // current word rebuilt from the stored fields
   always @* begin
      ctrl = `READ_ZERO;
      ctrl[`BIT_ENABLE] = enable;
      ctrl[`BIT_PIN_OE] = pin_request;
      ctrl[`BIT_RANGE] = range;
      ctrl[`BIT_SOURCE] = source;
      ctrl[`CODE_MSB:`CODE_LSB] = code;
   end

   // register update including alias addresses
   always @* begin
      next_ctrl = ctrl;
      if (write_hit) begin
         if (hit_base) begin
            next_ctrl = wmask;
         end else if (hit_clr) begin
            next_ctrl = ctrl & ~wmask;
         end else if (hit_set) begin
            next_ctrl = ctrl | wmask;
         end else if (hit_inv) begin
            next_ctrl = ctrl ^ wmask;
         end else begin
            next_ctrl = ctrl;
         end
      end
   end

   // field next values; alias writes touch only the bits
   // written as one, so the other fields hold
   always @* begin
      next_enable      = next_ctrl[`BIT_ENABLE];
      next_pin_request = next_ctrl[`BIT_PIN_OE];
      next_range       = next_ctrl[`BIT_RANGE];
      next_source      = next_ctrl[`BIT_SOURCE];
      next_code        = next_ctrl[`CODE_MSB:`CODE_LSB];
   end

   // drives from the next fields, so they move in step
   always @* begin
      next_power_down = ~next_enable;
      next_pin_drive  = next_pin_request & next_enable;
   end

   // tap decode on the next fields, flopped below
   ladder_tap_decode u_tap (
      .enable     (next_enable),
      .range_sel  (next_range),
      .code       (next_code),
      .tap_onehot (next_tap)
   );

   // read data: base and aliases return the word, others zero
   always @* begin
      next_rdata = `READ_ZERO;
      if (read_hit) begin
         next_rdata = ctrl & `CTRL_MASK;
      end
   end

   // module enable, changes only on a bus write
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         enable <= `ENABLE_RESET;
      end else begin
         enable <= next_enable;
      end
   end

   // pin enable as software wrote it
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_request <= `PIN_OE_RESET;
      end else begin
         pin_request <= next_pin_request;
      end
   end

   // range select
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         range <= `RANGE_RESET;
      end else begin
         range <= next_range;
      end
   end

   // source select
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         source <= `SOURCE_RESET;
      end else begin
         source <= next_source;
      end
   end

   // level code
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         code <= `CODE_RESET;
      end else begin
         code <= next_code;
      end
   end

   // ladder power down, high while the module is off
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         power_down <= `POWER_DOWN_RESET;
      end else begin
         power_down <= next_power_down;
      end
   end

   // pin connection, only while the ladder runs
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_drive <= `PIN_DRIVE_RESET;
      end else begin
         pin_drive <= next_pin_drive;
      end
   end

   // ladder tap, all zero while off
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tap <= `TAP_RESET;
      end else begin
         tap <= next_tap;
      end
   end

   // read data stands for one cycle only
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata <= `READ_ZERO;
      end else begin
         rdata <= next_rdata;
      end
   end

   // ladder drives come straight from flops
   assign ladder_enable           = enable;
   assign ladder_power_down       = power_down;
   assign level_pin_output_enable = pin_drive;
   assign range_select            = range;
   assign ladder_source_select    = source;
   assign level_code              = code;
   assign tap_select              = tap;
endmodule
`default_nettype wire

// >>> verification/reference_ladder_control_monitor.sv
`include "reference_ladder_regs.vh"
`default_nettype none
module reference_ladder_control_monitor (
   input wire logic        clk_sys,                 // system clock
   input wire logic        rst,                     // async reset
   input wire logic [15:0] addr,                    // byte address
   input wire logic [31:0] wdata,                   // write data
   input wire logic        wr,                      // write strobe
   input wire logic        rd,                      // read strobe
   input wire logic [31:0] rdata,                   // read data
   input wire logic        ladder_enable,           // ladder powered
   input wire logic        level_pin_output_enable, // level to pin
   input wire logic        range_select,            // range bit
   input wire logic        ladder_source_select,    // source bit
   input wire logic [3:0]  level_code,              // ladder code
   input wire logic        ladder_power_down,       // current off
   input wire logic [39:0] tap_select               // one-hot tap
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // alias writes that clear or set the enable bit
   sequence clear_enable_s;
      wr && addr == `REG_LEVEL_CONTROL_CLR && wdata[`BIT_ENABLE];
   endsequence
   sequence set_enable_s;
      wr && addr == `REG_LEVEL_CONTROL_SET && wdata[`BIT_ENABLE];
   endsequence
   power_tie_a:
   assert property (ladder_power_down != ladder_enable)
      else $error("power down is not the inverse of enable");
   tap_off_a:
   assert property (!ladder_enable |-> tap_select == `TAP_RESET)
      else $error("ladder tap selected while module is off");
   clear_off_a:
   assert property (clear_enable_s |=> !ladder_enable)
      else $error("clear alias left the ladder enabled");
   set_on_a:
   assert property (set_enable_s |=> ladder_enable)
      else $error("set alias did not enable the ladder");
   read_mask_a:
   assert property ((rdata & ~`CTRL_MASK) == `READ_ZERO)
      else $error("unimplemented read bits not zero");
   pin_gate_a:
   assert property (level_pin_output_enable |-> ladder_enable)
      else $error("level pin driven while ladder is off");
   tap_high_a:
   assert property (ladder_enable && range_select
      |-> tap_select == 40'h1 << level_code)
      else $error("high range tap mismatch");
   tap_low_a:
   assert property (ladder_enable && !range_select
      |-> tap_select == 40'h1 << (`TAP_LOW_BASE + level_code))
      else $error("low range tap mismatch");
   hold_ctrl_a:
   assert property (!$past(wr) |-> $stable({level_code, range_select,
      ladder_source_select, ladder_enable, level_pin_output_enable}))
      else $error("ladder controls changed without a write");
endmodule
`default_nettype wire

// >>> verification/reference_ladder_control_tb.sv
`default_nettype none
module reference_ladder_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 0, rst = 1, wr = 0, rd = 0, en, oe, rs, ss, pd;
   logic [15:0] addr = 16'h0000;
   logic [31:0] wdata = 32'h0000_0000, rdata, m = 32'h0000_0000;
   logic [3:0] lc;
   logic [39:0] ts;
   int fail_count = 0, checks_done = 0;
   // system clock
   always #10 clk_sys = ~clk_sys;
   reference_ladder_control i_dut (.clk_sys, .rst, .addr, .wdata, .wr, .rd,
      .rdata, .ladder_enable(en), .level_pin_output_enable(oe),
      .range_select(rs), .ladder_source_select(ss), .level_code(lc),
      .ladder_power_down(pd), .tap_select(ts));
   task chk(string n, logic [39:0] s, e);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   // one strobe cycle, sampled once its effect lands
   task acc(logic w, logic [15:0] ad, logic [31:0] d);
      @(posedge clk_sys) {wr, rd, addr, wdata} <= {w, !w, ad, d};
      @(posedge clk_sys) {wr, rd} <= 2'b00;
      #1;
   endtask
   // word after a write of d at ad, unmapped writes ignored
   function automatic logic [31:0] exp_ctrl(logic [15:0] ad,
         logic [31:0] old, logic [31:0] d);
      logic [31:0] r;
      case (ad)
         16'h9600: r = d;
         16'h9604: r = old & ~d;
         16'h9608: r = old | d;
         16'h960C: r = old ^ d;
         default:  r = old;
      endcase
      return r & 32'h0000_807F;
   endfunction
   // read data, ladder pins and tap expected from a word
   function automatic logic [31:0] exp_read(logic [15:0] ad,
         logic [31:0] c);
      return (ad inside {16'h9600, 16'h9604, 16'h9608, 16'h960C}) ?
         c : 32'h0000_0000;
   endfunction
   function automatic logic [8:0] exp_pins(logic [31:0] c);
      return {!c[15], c[15], c[6] & c[15], c[5:0]};
   endfunction
   function automatic logic [39:0] exp_tap(logic [31:0] c);
      return c[15] ? 40'h1 << (c[5] ? c[3:0] : 8 + c[3:0]) : 40'h0;
   endfunction
   // read back and compare bus and ladder with the model
   task look(logic [15:0] ad);
      acc(0, ad, 32'h0000_0000);
      chk("ctrl", rdata, exp_read(ad, m));
      chk("pins", {pd, en, oe, rs, ss, lc}, exp_pins(m));
      chk("tap", ts, exp_tap(m));
   endtask
   // write, model, read back after an idle cycle
   task op(logic [15:0] ad, logic [31:0] d);
      acc(1, ad, d);
      m = exp_ctrl(ad, m, d);
      look(ad);
   endtask
   task conclude;
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // reset, corners, then random traffic
   initial begin
      void'($urandom(17760));
      repeat (16) @(posedge clk_sys);
      rst <= 0;
      look(16'h9600);
      op(16'h9600, 32'hFFFF_FFFF);
      op(16'h9604, 32'h0000_8000);
      op(16'h9608, 32'h0000_8000);
      op(16'h960C, 32'hFFFF_FFFF);
      // mid-run reset clears every field again
      @(posedge clk_sys) rst <= 1;
      @(posedge clk_sys) rst <= 0;
      m = 32'h0000_0000;
      look(16'h9600);
      repeat (300) op(16'h9600 + 16'(4 * ($urandom % 5)), $urandom);
      conclude;
   end
endmodule
bind reference_ladder_control reference_ladder_control_monitor i_mon (
   .clk_sys, .rst, .addr, .wdata, .wr, .rd, .rdata, .ladder_enable,
   .level_pin_output_enable, .range_select, .ladder_source_select,
   .level_code, .ladder_power_down, .tap_select);
`default_nettype wire
